//--- design/radio_cmd_host.sv
// host controller that issues radio commands over spi from axi4-lite
// assumes a single 50 MHz clock; the spi clock is divided from it
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
`include "radio_ctl_defines.svh"
module radio_cmd_host import radio_ctl_pkg::*; #(
  parameter int HALF_CYCLES = 4,
  parameter int GAP_CYCLES = 4,
  parameter int BUF_BYTES = 16
) (
  // system
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [5:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [5:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // spi pins
  output logic sck,
  output logic mosi,
  output logic cs_n,
  input wire logic miso
);
  // ****************************************
  // command decoding helpers
  // ****************************************
  function automatic logic [2:0] param_count(input logic [7:0] op);
    case (op)
      `IMAGE_REJECTION_CAL_CMD: param_count = 3'd2;
      `AMP_SETUP_CMD: param_count = 3'd4;
      `POST_PACKET_MODE_CMD: param_count = 3'd1;
      `REG_BLOCK_STORE_CMD: param_count = 3'd2;
      `REG_BLOCK_FETCH_CMD: param_count = 3'd3;
      `PAYLOAD_STORE_CMD: param_count = 3'd1;
      `PAYLOAD_FETCH_CMD: param_count = 3'd2;
      default: param_count = 3'd0;
    endcase
  endfunction
  function automatic logic is_fetch(input logic [7:0] op);
    is_fetch = (op == `REG_BLOCK_FETCH_CMD) || (op == `PAYLOAD_FETCH_CMD);
  endfunction
  function automatic logic has_data(input logic [7:0] op);
    has_data = is_fetch(op) || (op == `REG_BLOCK_STORE_CMD) ||
               (op == `PAYLOAD_STORE_CMD);
  endfunction
  function automatic logic [7:0] byte_of(input logic [31:0] w,
                                         input logic [1:0] sel);
    byte_of = w[8*sel +: 8];
  endfunction
  function automatic logic amp_ok(input logic [31:0] p);
    amp_ok = (p[7:0] <= `AMP_CONDUCTION_MAX) && (p[15:8] <= `AMP_SIZE_MAX)
             && (p[23:16] == `AMP_VARIANT_VAL)
             && (p[31:24] == `AMP_TABLE_VAL);
  endfunction
  // ****************************************
  // registers
  // ****************************************
  ctl_state_t state_q;
  cmd_word_t cmd_q;
  logic [31:0] param_q;
  logic [31:0] xp_q;
  logic [7:0] op_q;
  logic [5:0] idx_q;
  logic [5:0] tot_q;
  logic [7:0] gap_q;
  logic [7:0] status_q;
  logic [7:0] mode_q;
  logic refused_q;
  logic [7:0] buf_q [0:BUF_BYTES-1];
  logic eng_done;
  logic [7:0] eng_rx;
  // ****************************************
  // axi4-lite decode and command launch
  // ****************************************
  wire wr_fire = awvalid && wvalid && !bvalid;
  wire [3:0] wr_idx = awaddr[5:2];
  wire [3:0] rd_idx = araddr[5:2];
  wire wr_data_area = (wr_idx >= `DATA_REG_FIRST) &&
                      (wr_idx <= `DATA_REG_LAST);
  wire rd_data_area = (rd_idx >= `DATA_REG_FIRST) &&
                      (rd_idx <= `DATA_REG_LAST);
  wire wr_mapped = wr_data_area || (wr_idx <= `STATUS_REG_OFF);
  wire rd_mapped = rd_data_area || (rd_idx <= `STATUS_REG_OFF);
  wire [3:0] wr_base = {wr_idx[1:0], 2'b00};
  wire [3:0] rd_base = {rd_idx[1:0], 2'b00};
  wire idle = (state_q == ST_IDLE);
  wire ar_fire = arvalid && !rvalid;
  assign awready = wr_fire;
  assign wready = wr_fire;
  assign arready = !rvalid;
  cmd_word_t new_cmd;
  assign new_cmd = cmd_word_t'(wdata);
  wire cmd_write = wr_fire && (wr_idx == `CMD_REG_OFF);
  wire [7:0] new_op = new_cmd.opcode;
  wire [2:0] new_pc = param_count(new_op);
  wire [1:0] pre = new_cmd.preset;
  wire [7:0] pre_duty = (pre == 2'd0) ? 8'h04 :
                        (pre == 2'd1) ? 8'h03 : 8'h02;
  wire [7:0] pre_size = (pre == 2'd0) ? 8'h07 :
                        (pre == 2'd1) ? 8'h05 :
                        (pre == 2'd2) ? 8'h03 : 8'h02;
  wire use_preset = (new_op == `AMP_SETUP_CMD) && new_cmd.preset_en;
  wire [31:0] eff_param = use_preset ?
    {`AMP_TABLE_VAL, `AMP_VARIANT_VAL, pre_size, pre_duty} : param_q;
  wire mode_ok = (eff_param[7:0] == `SYNTH_READY_STATE) ||
                 (eff_param[7:0] == `CRYSTAL_STANDBY_STATE) ||
                 (eff_param[7:0] == `RC_STANDBY_STATE);
  wire new_len_ok = {1'b0, new_cmd.len} <= 6'(BUF_BYTES);
  wire new_ok = (new_pc != 3'd0) && new_len_ok &&
                ((new_op != `AMP_SETUP_CMD) || amp_ok(eff_param)) &&
                ((new_op != `POST_PACKET_MODE_CMD) || mode_ok);
  wire go = cmd_write && idle && new_ok;
  wire [5:0] new_len = has_data(new_op) ? {1'b0, new_cmd.len} : 6'd0;
  wire [5:0] new_tot = 6'd1 + {3'd0, new_pc} + new_len;
  // link byte selection
  wire [5:0] pc6 = {3'd0, param_count(op_q)};
  wire in_params = (idx_q != 6'd0) && (idx_q <= pc6);
  wire [3:0] dpos = 4'(idx_q - 6'd1 - pc6);
  wire [1:0] ppos = 2'(idx_q - 6'd1);
  wire is_dummy = is_fetch(op_q) && (idx_q == pc6);
  wire [7:0] tx_sel = (idx_q == 6'd0) ? op_q :
                      is_dummy ? `NOP_BYTE :
                      in_params ? byte_of(xp_q, ppos) :
                      is_fetch(op_q) ? `NOP_BYTE :
                      buf_q[dpos];
  wire last_byte = (idx_q == tot_q - 6'd1);
  spi_byte_engine #(
    .HALF_CYCLES(HALF_CYCLES)
  ) u_engine (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(state_q == ST_SEND),
    .tx_byte(tx_sel),
    .done(eng_done),
    .rx_byte(eng_rx),
    .sck(sck),
    .mosi(mosi),
    .miso(miso)
  );
  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      cs_n <= 1'b1;
      idx_q <= 6'd0;
      tot_q <= 6'd1;
      gap_q <= 8'h00;
      op_q <= 8'h00;
      xp_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (go) begin
            op_q <= new_op;
            xp_q <= eff_param;
            tot_q <= new_tot;
            idx_q <= 6'd0;
            cs_n <= 1'b0;
            state_q <= ST_SEND;
          end
        end
        ST_SEND: state_q <= ST_WAIT;
        ST_WAIT: begin
          if (eng_done) begin
            if (last_byte) begin
              cs_n <= 1'b1;
              gap_q <= 8'h00;
              state_q <= ST_GUARD;
            end else begin
              idx_q <= idx_q + 6'd1;
              state_q <= ST_SEND;
            end
          end
        end
        ST_GUARD: begin
          if (gap_q == 8'(GAP_CYCLES - 1)) begin
            state_q <= ST_IDLE;
          end else begin
            gap_q <= gap_q + 8'h01;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  // ****************************************
  // register file, captured data and bus answers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_q <= cmd_word_t'(32'h0000_0000);
      param_q <= `PARAM_RESET;
      status_q <= 8'h00;
      mode_q <= `RC_STANDBY_STATE;
      refused_q <= 1'b0;
      for (int i = 0; i < BUF_BYTES; i++) begin
        buf_q[i] <= 8'h00;
      end
    end else begin
      if (cmd_write && idle) begin
        cmd_q <= new_cmd;
        refused_q <= !new_ok;
      end
      if (wr_fire && idle && (wr_idx == `PARAM_REG_OFF)) begin
        param_q <= wdata;
      end
      if (wr_fire && idle && wr_data_area) begin
        for (int b = 0; b < 4; b++) begin
          if (wstrb[b]) begin
            buf_q[wr_base + 4'(b)] <= wdata[8*b +: 8];
          end
        end
      end
      if (state_q == ST_WAIT && eng_done) begin
        if (idx_q == 6'd1) begin
          status_q <= eng_rx;
        end
        if (is_fetch(op_q) && idx_q > pc6) begin
          buf_q[dpos] <= eng_rx;
        end
        if (last_byte && op_q == `POST_PACKET_MODE_CMD) begin
          mode_q <= xp_q[7:0];
        end
      end
    end
  end
  wire [31:0] status_word = {8'h00, mode_q, status_q, 6'd0, refused_q,
                             !idle};
  wire [31:0] data_word = {buf_q[rd_base + 4'd3], buf_q[rd_base + 4'd2],
                           buf_q[rd_base + 4'd1], buf_q[rd_base]};
  wire [31:0] rd_word = (rd_idx == `CMD_REG_OFF) ? 32'(cmd_q) :
                        (rd_idx == `PARAM_REG_OFF) ? param_q :
                        (rd_idx == `STATUS_REG_OFF) ? status_word :
                        rd_data_area ? data_word : 32'h0000_0000;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `AXI_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `AXI_OKAY;
    end else begin
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= wr_mapped ? `AXI_OKAY : `AXI_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      if (ar_fire) begin
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= rd_mapped ? `AXI_OKAY : `AXI_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end
  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  cs_release_a: assert property (
    (state_q == ST_WAIT && eng_done && last_byte) |=> cs_n [*2])
    else $error("chip select not released after last byte");
  amp_duty_a: assert property (
    (go && new_op == `AMP_SETUP_CMD) |=> xp_q[7:0] <= 8'h04)
    else $error("amplifier duty byte above limit");
  amp_size_a: assert property (
    (state_q == ST_SEND && op_q == `AMP_SETUP_CMD && idx_q == 6'd2)
    |-> tx_sel <= 8'h07)
    else $error("amplifier size byte above limit");
  amp_reserved_a: assert property (
    (state_q == ST_SEND && op_q == `AMP_SETUP_CMD && idx_q >= 6'd3)
    |-> tx_sel == ((idx_q == 6'd3) ? 8'h00 : 8'h01))
    else $error("amplifier reserved bytes wrong");
  opcode_first_a: assert property (
    (state_q == ST_IDLE && go) |=> (idx_q == 6'd0 && tx_sel == $past(new_op)
    && !cs_n))
    else $error("first byte is not the opcode");
  fetch_nop_a: assert property (
    (state_q == ST_SEND && is_fetch(op_q) && idx_q >= pc6) |-> tx_sel == 8'h00)
    else $error("fetch dummy byte not zero");
  mode_reset_a: assert property (
    $rose(aresetn) |-> mode_q == 8'h20)
    else $error("post packet mode not rc standby after reset");
  refuse_bad_a: assert property (
    (cmd_write && idle && !new_ok) |=> (state_q == ST_IDLE && refused_q))
    else $error("illegal command was launched");
  status_take_a: assert property (
    (state_q == ST_WAIT && eng_done && idx_q == 6'd1) |=> status_q ==
    $past(eng_rx))
    else $error("status byte not captured");
  amp_cmd_c: cover property (go && new_op == `AMP_SETUP_CMD);
  reg_fetch_c: cover property (state_q == ST_GUARD &&
    op_q == `REG_BLOCK_FETCH_CMD);
  pay_store_c: cover property (state_q == ST_GUARD &&
    op_q == `PAYLOAD_STORE_CMD);
  refused_c: cover property (cmd_write && idle && !new_ok);
endmodule

//--- design/radio_ctl_defines.svh
// constants of the radio command controller: opcodes, codes, offsets
// assumes the package radio_ctl_pkg is compiled alongside
`ifndef RADIO_CTL_DEFINES_SVH
`define RADIO_CTL_DEFINES_SVH
// ****************************************
// command opcodes
// ****************************************
`define IMAGE_REJECTION_CAL_CMD 8'h98
`define AMP_SETUP_CMD 8'h95
`define POST_PACKET_MODE_CMD 8'h93
`define REG_BLOCK_STORE_CMD 8'h0D
`define REG_BLOCK_FETCH_CMD 8'h1D
`define PAYLOAD_STORE_CMD 8'h0E
`define PAYLOAD_FETCH_CMD 8'h1E
// ****************************************
// parameter byte values
// ****************************************
`define AMP_CONDUCTION_MAX 8'h04
`define AMP_SIZE_MAX 8'h07
`define AMP_VARIANT_VAL 8'h00
`define AMP_TABLE_VAL 8'h01
`define SYNTH_READY_STATE 8'h40
`define CRYSTAL_STANDBY_STATE 8'h30
`define RC_STANDBY_STATE 8'h20
`define NOP_BYTE 8'h00
// ****************************************
// controller register offsets and reset values
// ****************************************
`define CMD_REG_OFF 4'h0
`define PARAM_REG_OFF 4'h1
`define STATUS_REG_OFF 4'h2
`define DATA_REG_FIRST 4'h4
`define DATA_REG_LAST 4'h7
`define PARAM_RESET 32'h0000_0000
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

//--- design/radio_ctl_pkg.sv
// types shared by the radio command controller
// assumes nothing beyond a SystemVerilog compiler
package radio_ctl_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_WAIT = 2'b10,
    ST_GUARD = 2'b11
  } ctl_state_t;

  // command register layout
  typedef struct packed {
    logic [12:0] rsv_hi;
    logic [1:0] preset;
    logic preset_en;
    logic [2:0] rsv_lo;
    logic [4:0] len;
    logic [7:0] opcode;
  } cmd_word_t;
endpackage

//--- design/spi_byte_engine.sv
// one-byte spi shifter, clock idle low, sample on falling edge
// assumes half_cycles of at least 3 so the synchronised input settles
`timescale 1ns/1ns
module spi_byte_engine #(
  parameter int HALF_CYCLES = 4
) (
  // system
  input wire logic aclk,
  input wire logic aresetn,
  // byte request and answer
  input wire logic start,
  input wire logic [7:0] tx_byte,
  output logic done,
  output logic [7:0] rx_byte,
  // pins
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  logic [7:0] div_q;
  logic [2:0] bit_q;
  logic active_q;
  logic [7:0] sh_q;
  logic miso_m_q;
  logic miso_s_q;
  wire div_end = (div_q == 8'(HALF_CYCLES - 1));

  always_ff @(posedge aclk) begin
    miso_m_q <= miso;
    miso_s_q <= miso_m_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 8'h00;
      bit_q <= 3'd0;
      active_q <= 1'b0;
      sh_q <= 8'h00;
      sck <= 1'b0;
      mosi <= 1'b0;
      done <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      done <= 1'b0;
      if (!active_q) begin
        if (start) begin
          active_q <= 1'b1;
          sh_q <= tx_byte;
          mosi <= tx_byte[7];
          bit_q <= 3'd7;
          div_q <= 8'h00;
        end
      end else if (!div_end) begin
        div_q <= div_q + 8'h01;
      end else begin
        div_q <= 8'h00;
        if (!sck) begin
          sck <= 1'b1;
        end else begin
          // sample at the end of the high phase
          rx_byte <= {rx_byte[6:0], miso_s_q};
          sck <= 1'b0;
          if (bit_q == 3'd0) begin
            active_q <= 1'b0;
            done <= 1'b1;
          end else begin
            bit_q <= bit_q - 3'd1;
            sh_q <= {sh_q[6:0], 1'b0};
            mosi <= sh_q[6];
          end
        end
      end
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  done_single_a: assert property (done |=> !done)
    else $error("done held longer than one cycle");
  sck_idle_a: assert property (!active_q |-> !sck)
    else $error("sck high while idle");
endmodule

//--- tb/radio_dev_model.sv
// behavioural radio device on the far side of the spi pins
// assumes clock idle low, bits sampled on the rising sck edge, msb first
`timescale 1ns/1ns
module radio_dev_model #(
  parameter logic [7:0] STATUS_BYTE = 8'h52,
  parameter logic [7:0] RSV_BYTE = 8'hA5
) (
  // spi pins
  input wire logic sck,
  input wire logic mosi,
  input wire logic cs_n,
  output logic miso
);
  logic [7:0] sh_in, sh_out, opcode, off;
  logic [7:0] prm [1:4];
  logic [15:0] cal_band;
  // duty, size, variant, table bytes in the order sent
  logic [31:0] amp_cfg;
  logic [7:0] post_packet_mode_code = 8'h20;
  logic [15:0] addr;
  logic [7:0] regs [0:65535];
  logic [7:0] pay_mem [0:255];
  int bit_n, idx;
  int frames = 0;
  initial miso = 1'b0;

  // ****************************************
  // framing and reply
  // ****************************************
  always @(negedge cs_n) begin
    frames++;
    bit_n = 0;
    idx = 0;
    sh_out = RSV_BYTE;
    miso = sh_out[7];
  end
  // a released line shows the inverse of its last level
  always @(posedge cs_n) miso = ~miso;

  always @(negedge sck) if (!cs_n) begin
    if (bit_n == 8) begin
      bit_n = 0;
      sh_out = STATUS_BYTE;
      if (opcode == 8'h1D && idx >= 4) begin
        sh_out = regs[addr];
        addr++;
      end
      if (opcode == 8'h1E && idx >= 3) begin
        sh_out = pay_mem[off];
        off++;
      end
    end
    miso = sh_out[7 - bit_n];
  end

  // ****************************************
  // command decode
  // ****************************************
  always @(posedge sck) if (!cs_n) begin
    sh_in = {sh_in[6:0], mosi};
    bit_n++;
    if (bit_n == 8) begin
      if (idx == 0) opcode = sh_in;
      else if (idx <= 4) prm[idx] = sh_in;
      if (idx == 1) off = sh_in;
      if (idx == 2) addr = {prm[1], sh_in};
      if (opcode == 8'h98 && idx == 2) cal_band = {sh_in, prm[1]};
      if (opcode == 8'h95 && idx == 4)
        amp_cfg = {prm[1], prm[2], prm[3], sh_in};
      if (opcode == 8'h93 && idx == 1 && sh_in inside {8'h40, 8'h30, 8'h20})
        post_packet_mode_code = sh_in;
      if (opcode == 8'h0D && idx >= 3) begin
        regs[addr] = sh_in;
        addr++;
      end
      if (opcode == 8'h0E && idx >= 2) begin
        pay_mem[off] = sh_in;
        off++;
      end
      idx++;
    end
  end
endmodule

//--- tb/testbench.sv
// self-checking bench for the radio command host
// assumes the device model answers on the spi pins
`timescale 1ns/1ns
module testbench;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0;
  logic [5:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 0;
  wire awready, wready, bvalid, arready, rvalid, sck, mosi, cs_n, miso;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int n_mismatch = 0, samples_checked = 0, cycles = 0;
  logic [31:0] st, d;
  logic [1:0] r;
  int f0;

  always #10 aclk = ~aclk;

  radio_cmd_host #(.HALF_CYCLES(3), .GAP_CYCLES(1)) dut (.aclk(aclk),
    .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .sck(sck), .mosi(mosi), .cs_n(cs_n), .miso(miso));
  radio_dev_model dev (.sck(sck), .mosi(mosi), .cs_n(cs_n), .miso(miso));

  // ****************************************
  // common tasks
  // ****************************************
  task close_out;
    if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 80000) begin
      n_mismatch++;
      close_out;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task axi_wr(input logic [5:0] a, input logic [31:0] v, input logic [3:0] s);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task axi_rd(input logic [5:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    r = rresp;
    d = rdata;
    rready <= 1'b0;
  endtask

  task wr(input logic [5:0] a, input logic [31:0] v);
    axi_wr(a, v, 4'hf);
    chk(r, 2'h0);
  endtask

  // writes parameters and command, then polls until idle
  task run(input logic [31:0] cmd, input logic [31:0] par);
    f0 = dev.frames;
    wr(6'h04, par);
    wr(6'h00, cmd);
    do axi_rd(6'h08); while (d[0] !== 1'b0);
    st = d;
  endtask

  function automatic logic [31:0] cw(logic [7:0] op, logic [4:0] n,
                                     logic [2:0] pre);
    cw = {13'h0, pre[1:0], pre[2], 3'h0, n, op};
  endfunction

  // ****************************************
  // scenarios
  // ****************************************
  task t_reset;
    axi_rd(6'h08);
    chk(d, 32'h0020_0000);
    axi_rd(6'h0C);
    chk(d, 32'h0000_0000);
    chk(r, 2'h2);
    axi_wr(6'h20, 32'h0000_0001, 4'hf);
    chk(r, 2'h2);
    wr(6'h14, 32'h0000_0000);
    axi_wr(6'h14, 32'hFFFF_FF55, 4'h1);
    axi_rd(6'h14);
    chk(d, 32'h0000_0055);
  endtask

  task t_regs;
    wr(6'h10, 32'h4433_2211);
    run(cw(8'h0D, 5'd4, 3'h0), 32'h0000_3412);
    for (int k = 0; k < 4; k++)
      chk(dev.regs[16'h1234 + k], 8'h11 * (k + 1));
    wr(6'h10, 32'h0);
    run(cw(8'h1D, 5'd4, 3'h0), 32'h0000_3412);
    axi_rd(6'h10);
    chk(d, 32'h4433_2211);
    chk(st[15:8], 8'h52);
    chk(dev.frames - f0, 1);
  endtask

  task t_payload;
    wr(6'h10, 32'hD4C3_B2A1);
    run(cw(8'h0E, 5'd4, 3'h0), 32'h0000_00FE);
    chk({dev.pay_mem[8'hFE], dev.pay_mem[8'hFF]}, 16'hA1B2);
    chk({dev.pay_mem[8'h00], dev.pay_mem[8'h01]}, 16'hC3D4);
    wr(6'h10, 32'h0);
    run(cw(8'h1E, 5'd4, 3'h0), 32'h0000_00FE);
    axi_rd(6'h10);
    chk(d, 32'hD4C3_B2A1);
  endtask

  task t_amp;
    logic [31:0] exp [4];
    exp = '{32'h0407_0001, 32'h0305_0001, 32'h0203_0001, 32'h0202_0001};
    for (int p = 0; p < 4; p++) begin
      run(cw(8'h95, 5'd0, {1'b1, p[1:0]}), 32'h0);
      chk(dev.amp_cfg, exp[p]);
    end
    run(cw(8'h95, 5'd0, 3'h0), 32'h0100_0705);
    chk({st[1], 31'(dev.frames - f0)}, {1'b1, 31'd0});
    run(cw(8'h95, 5'd0, 3'h0), 32'h0100_0804);
    chk({st[1], 31'(dev.frames - f0)}, {1'b1, 31'd0});
    run(cw(8'h95, 5'd0, 3'h0), 32'h0101_0704);
    chk({st[1], 31'(dev.frames - f0)}, {1'b1, 31'd0});
    run(cw(8'h95, 5'd0, 3'h0), 32'h0100_0304);
    chk(dev.amp_cfg, 32'h0403_0001);
  endtask

  task t_mode;
    logic [7:0] m [3];
    m = '{8'h20, 8'h40, 8'h30};
    for (int k = 0; k < 3; k++) begin
      run(cw(8'h93, 5'd0, 3'h0), {24'h0, m[k]});
      chk(dev.post_packet_mode_code, m[k]);
      chk(st[23:16], m[k]);
    end
    run(cw(8'h93, 5'd0, 3'h0), 32'h0000_0050);
    chk({st[1], st[23:16]}, {1'b1, 8'h30});
  endtask

  task t_cal;
    run(cw(8'h98, 5'd0, 3'h0), 32'h0000_6F6B);
    chk(dev.cal_band, 16'h6F6B);
    chk({dev.opcode, 24'(dev.frames - f0)}, {8'h98, 24'd1});
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_regs;
    t_payload;
    t_amp;
    t_mode;
    t_cal;
    close_out;
  end
endmodule
